// ==== rtl/mlx_pkg.sv ====
// mlx_pkg: constants for the literal, store and indirect-store executor.
// assumes a 32-bit apb slave with word-aligned registers and a 14-bit opcode.
package mlx_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_ACC = 8'h04;
    localparam logic [7:0] OFS_BANK = 8'h08;
    localparam logic [7:0] OFS_PCH = 8'h0c;
    localparam logic [7:0] OFS_OPTION = 8'h10;
    localparam logic [7:0] OFS_PTR0 = 8'h14;
    localparam logic [7:0] OFS_PTR1 = 8'h18;
    localparam logic [7:0] OFS_POWER_CONTROL_REG = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_PC = 8'h24;
    localparam logic [7:0] OFS_CORE = 8'h28;

    // values after reset
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [4:0] RST_BANK = 5'h00;
    localparam logic [6:0] RST_PCH = 7'h00;
    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [14:0] RST_PC = 15'h0000;
    localparam logic RST_RIFLAG = 1'b1;

    // opcode masks and match values
    localparam logic [13:0] MSK_BANK = 14'h3fe0;
    localparam logic [13:0] OPC_BANK = 14'h0020;
    localparam logic [13:0] MSK_PAGE = 14'h3f80;
    localparam logic [13:0] OPC_PAGE = 14'h3180;
    localparam logic [13:0] MSK_LIT = 14'h3f00;
    localparam logic [13:0] OPC_LIT = 14'h3000;
    localparam logic [13:0] MSK_FILE = 14'h3f80;
    localparam logic [13:0] OPC_FILE = 14'h0080;
    localparam logic [13:0] MSK_IND = 14'h3ff8;
    localparam logic [13:0] OPC_IND = 14'h0018;
    localparam logic [13:0] MSK_OFS = 14'h3f80;
    localparam logic [13:0] OPC_OFS = 14'h3f80;
    localparam logic [13:0] OPC_NOP = 14'h0000;
    localparam logic [13:0] OPC_OPTION = 14'h0062;
    localparam logic [13:0] OPC_RESET = 14'h0001;

    // field positions inside the opcode
    localparam int SEL_POS = 2;
    localparam int SEL_POS_OFS = 6;

    // pointer update modes
    localparam logic [1:0] MODE_PREINC = 2'b00;
    localparam logic [1:0] MODE_PREDEC = 2'b01;
    localparam logic [1:0] MODE_POSTINC = 2'b10;
    localparam logic [1:0] MODE_POSTDEC = 2'b11;

    // executor states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } mlx_state_t;
endpackage

// ==== rtl/mlx_ptr_unit.sv ====
// mlx_ptr_unit: effective address and follow-up value of one indirect pointer.
// assumes the caller decides whether the follow-up value is stored.
`timescale 1ns/1ns
module mlx_ptr_unit (
    input wire logic [15:0] ptr,
    input wire logic [1:0] mode,
    input wire logic offsetForm,
    input wire logic [5:0] offset,
    output logic [15:0] effAddr,
    output logic [15:0] nextPtr
);
    import mlx_pkg::*;

    logic [15:0] ptrInc;
    logic [15:0] ptrDec;
    logic [15:0] ptrOfs;

    // 16-bit arithmetic wraps at both ends by itself
    assign ptrInc = ptr + 16'h0001;
    assign ptrDec = ptr - 16'h0001;
    assign ptrOfs = ptr + {{10{offset[5]}}, offset};

    // address used now and value left behind
    always_comb begin
        effAddr = ptr;
        nextPtr = ptr;
        if (offsetForm) begin
            effAddr = ptrOfs;
            nextPtr = ptr;
        end else begin
            case (mode)
                MODE_PREINC: begin
                    effAddr = ptrInc;
                    nextPtr = ptrInc;
                end
                MODE_PREDEC: begin
                    effAddr = ptrDec;
                    nextPtr = ptrDec;
                end
                MODE_POSTINC: begin
                    nextPtr = ptrInc;
                end
                default: begin
                    nextPtr = ptrDec;
                end
            endcase
        end
    end
endmodule

// ==== rtl/mlx_exec.sv ====
// mlx_exec: executes the literal-load, store, indirect-store, no-op, option
// and software-reset instructions written into the opcode register.
// assumes an apb master on clk_sys and a data store behind the write port.
//
// How it works
// - the bank-load instruction puts its 5-bit literal into the bank select register.
// - the page-load instruction puts its 7-bit literal into the pc high latch.
// - the literal-load instruction puts its 8-bit literal into the accumulator.
// - the file store copies the accumulator to the file address 0 to 127 in the bank.
// - the indirect store addresses pointer+1, pointer-1, the pointer itself or pointer plus offset -32..31.
// - after the indirect store the pointer is incremented, decremented or kept.
// - the update mode field decodes 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - a store to an indirect window goes to the address held by its pointer.
// - each 16-bit pointer wraps around at 0000h and FFFFh.
// - neither the pointer update nor the store changes the status register.
// - the option-load instruction copies the accumulator into the option register.
// - the software reset requests a full device reset and resets the core state; the status register keeps its value.
// - the software reset clears the reset-instruction flag in power control.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module mlx_exec (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic memWrEn,
    output logic [15:0] memAddr,
    output logic [7:0] memData,
    output logic swResetReq
);
    import mlx_pkg::*;

    mlx_state_t state;
    logic [13:0] instr;
    logic [7:0] acc;
    logic [4:0] bankSelectReg;
    logic [6:0] pcHighLatch;
    logic [7:0] optionReg;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic resetInstrFlag;
    logic [7:0] statusReg;
    logic [14:0] pc;

    logic execNow;
    logic apbAccess;
    logic apbWrite;
    logic mapped;
    logic [31:0] readMux;
    logic isBank, isPage, isLit, isFile, isInd, isOfs, isOption, isReset;
    logic indSel;
    logic [15:0] ea0, ea1, nxt0, nxt1;
    logic [15:0] indAddr;
    logic [15:0] fileAddr;

    assign execNow = (state == ST_EXEC);
    assign apbAccess = psel && penable;

    // writes wait while an instruction executes, so no register has two writers at once
    assign pready = !(apbAccess && pwrite && execNow);
    assign apbWrite = apbAccess && pwrite && pready;

    // opcode decode
    assign isBank = (instr & MSK_BANK) == OPC_BANK;
    assign isPage = (instr & MSK_PAGE) == OPC_PAGE;
    assign isLit = (instr & MSK_LIT) == OPC_LIT;
    assign isFile = (instr & MSK_FILE) == OPC_FILE;
    assign isInd = (instr & MSK_IND) == OPC_IND;
    assign isOfs = (instr & MSK_OFS) == OPC_OFS;
    assign isOption = instr == OPC_OPTION;
    assign isReset = instr == OPC_RESET;
    assign indSel = isOfs ? instr[SEL_POS_OFS] : instr[SEL_POS];

    // one address unit per pointer; only the selected result is used
    mlx_ptr_unit u_ptr0 (
        .ptr(ptr0),
        .mode(instr[1:0]),
        .offsetForm(isOfs),
        .offset(instr[5:0]),
        .effAddr(ea0),
        .nextPtr(nxt0)
    );
    mlx_ptr_unit u_ptr1 (
        .ptr(ptr1),
        .mode(instr[1:0]),
        .offsetForm(isOfs),
        .offset(instr[5:0]),
        .effAddr(ea1),
        .nextPtr(nxt1)
    );
    assign indAddr = indSel ? ea1 : ea0;

    // file 0 and 1 are windows, not storage: they stand for the pointer targets
    assign fileAddr = (instr[6:1] == 6'h00) ? (instr[0] ? ptr1 : ptr0)
        : {4'h0, bankSelectReg, instr[6:0]};

    // executor: an opcode write starts one execute cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            instr <= OPC_NOP;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (apbWrite && paddr == OFS_INSTR) begin
                        instr <= pwdata[13:0];
                        state <= ST_EXEC;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // accumulator, bank, page latch, option
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acc <= RST_ACC;
            bankSelectReg <= RST_BANK;
            pcHighLatch <= RST_PCH;
            optionReg <= RST_OPTION;
        end else if (execNow) begin
            if (isReset) begin
                acc <= RST_ACC;
                bankSelectReg <= RST_BANK;
                pcHighLatch <= RST_PCH;
                optionReg <= RST_OPTION;
            end else if (isBank) begin
                bankSelectReg <= instr[4:0];
            end else if (isPage) begin
                pcHighLatch <= instr[6:0];
            end else if (isLit) begin
                acc <= instr[7:0];
            end else if (isOption) begin
                optionReg <= acc;
            end
        end else if (apbWrite) begin
            if (paddr == OFS_ACC) begin
                acc <= pwdata[7:0];
            end else if (paddr == OFS_BANK) begin
                bankSelectReg <= pwdata[4:0];
            end else if (paddr == OFS_PCH) begin
                pcHighLatch <= pwdata[6:0];
            end else if (paddr == OFS_OPTION) begin
                optionReg <= pwdata[7:0];
            end
        end
    end

    // indirect pointers: an indirect store moves only the selected one; the software reset clears both
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ptr0 <= RST_PTR;
            ptr1 <= RST_PTR;
        end else if (execNow) begin
            if (isReset) begin
                ptr0 <= RST_PTR;
                ptr1 <= RST_PTR;
            end else if ((isInd || isOfs) && !indSel) begin
                ptr0 <= nxt0;
            end else if (isInd || isOfs) begin
                ptr1 <= nxt1;
            end
        end else if (apbWrite) begin
            if (paddr == OFS_PTR0) begin
                ptr0 <= pwdata[15:0];
            end else if (paddr == OFS_PTR1) begin
                ptr1 <= pwdata[15:0];
            end
        end
    end

    // status is written only by software here; no instruction of this group touches it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            statusReg <= RST_STATUS;
        end else if (apbWrite && paddr == OFS_STATUS) begin
            statusReg <= pwdata[7:0];
        end
    end

    // reset-instruction flag: cleared by the instruction, set again by writing 1
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            resetInstrFlag <= RST_RIFLAG;
        end else if (execNow && isReset) begin
            resetInstrFlag <= 1'b0;
        end else if (apbWrite && paddr == OFS_POWER_CONTROL_REG && pwdata[0]) begin
            resetInstrFlag <= 1'b1;
        end
    end

    // program counter: every instruction is one word and one cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pc <= RST_PC;
        end else if (execNow) begin
            if (isReset) begin
                pc <= RST_PC;
            end else begin
                pc <= pc + 15'h0001;
            end
        end
    end

    // store port and reset request, one-cycle pulses after the execute cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            memWrEn <= 1'b0;
            memAddr <= 16'h0000;
            memData <= 8'h00;
            swResetReq <= 1'b0;
        end else begin
            memWrEn <= execNow && (isFile || isInd || isOfs);
            swResetReq <= execNow && isReset;
            if (execNow && isFile) begin
                memAddr <= fileAddr;
                memData <= acc;
            end else if (execNow && (isInd || isOfs)) begin
                memAddr <= indAddr;
                memData <= acc;
            end
        end
    end

    // unmapped addresses answer with an error and read as zero
    always_comb begin
        readMux = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == OFS_INSTR) begin
            readMux = {18'h00000, instr};
        end else if (paddr == OFS_ACC) begin
            readMux = {24'h000000, acc};
        end else if (paddr == OFS_BANK) begin
            readMux = {27'h0000000, bankSelectReg};
        end else if (paddr == OFS_PCH) begin
            readMux = {25'h0000000, pcHighLatch};
        end else if (paddr == OFS_OPTION) begin
            readMux = {24'h000000, optionReg};
        end else if (paddr == OFS_PTR0) begin
            readMux = {16'h0000, ptr0};
        end else if (paddr == OFS_PTR1) begin
            readMux = {16'h0000, ptr1};
        end else if (paddr == OFS_POWER_CONTROL_REG) begin
            readMux = {31'h00000000, resetInstrFlag};
        end else if (paddr == OFS_STATUS) begin
            readMux = {24'h000000, statusReg};
        end else if (paddr == OFS_PC) begin
            readMux = {17'h00000, pc};
        end else if (paddr == OFS_CORE) begin
            readMux = {31'h00000000, execNow};
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = apbAccess && pready && !mapped;

    // read data is taken into a flop in the setup cycle and stands through the access phase;
    // a register that an instruction changes in that same cycle still reads its old value
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= readMux;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence sIndStart;
        execNow && (isInd || isOfs);
    endsequence
    sequence sRst;
        execNow && isReset;
    endsequence

    chk_bank_load: assert property (execNow && isBank |=>
        bankSelectReg == $past(instr[4:0]) && $stable(acc))
        else $error("bank load did not take the literal");
    chk_page_load: assert property (execNow && isPage |=>
        pcHighLatch == $past(instr[6:0]))
        else $error("page latch load wrong");
    chk_acc_literal: assert property (execNow && isLit |=>
        acc == $past(instr[7:0]) && $stable(statusReg))
        else $error("accumulator literal load wrong");
    chk_file_store: assert property (execNow && isFile && instr[6:1] != 6'h00 |=>
        memWrEn && memData == $past(acc) && memAddr[6:0] == $past(instr[6:0]))
        else $error("file store wrong");
    chk_window_redirect: assert property (execNow && isFile && instr == OPC_FILE |=>
        memWrEn && memAddr == $past(ptr0))
        else $error("window store not redirected");
    chk_preinc_wrap: assert property (sIndStart ##0 (isInd && instr[2:0] == 3'b000) |=>
        ptr0 == $past(ptr0) + 16'h0001 && memAddr == ptr0 ##1 !memWrEn)
        else $error("pre-increment address or pointer wrong");
    chk_postdec_sel: assert property (sIndStart ##0 (isInd && instr[2:0] == 3'b111) |=>
        ptr1 == $past(ptr1) - 16'h0001 && $stable(ptr0) && memAddr == $past(ptr1))
        else $error("post-decrement on pointer one wrong");
    chk_offset_hold: assert property (sIndStart ##0 isOfs |=>
        $stable(ptr0) && $stable(ptr1) && memWrEn)
        else $error("offset form moved a pointer");
    chk_status_hold: assert property (sIndStart |=> $stable(statusReg))
        else $error("indirect store changed status");
    chk_option_load: assert property (execNow && isOption |=>
        optionReg == $past(acc))
        else $error("option load wrong");
    chk_sw_reset: assert property (sRst |=>
        swResetReq && !resetInstrFlag && pc == RST_PC ##1 !swResetReq)
        else $error("software reset did not act");
    chk_nop_only_pc: assert property (execNow && instr == OPC_NOP |=>
        pc == $past(pc) + 15'h0001 && $stable(acc) && !memWrEn)
        else $error("no-op changed state");
endmodule

// ==== verification/tb_top.sv ====
// tb_top: self-checking bench for the literal, store and indirect-store executor.
// assumes the apb slave answers by its own pready and stores appear as memWrEn pulses.
`timescale 1ns/1ns
module tb_top;
    import mlx_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, memWrEn, swResetReq;
    logic [15:0] memAddr, lastAddr;
    logic [7:0] memData, lastData, acc, bnk, sts;
    logic [31:0] rd;
    logic err;
    logic [15:0] p0, p1, pv;
    logic [6:0] f;
    logic [5:0] k;
    int errors = 0, tests_run = 0, seed = 79388, storeCount = 0, resetCount = 0, prev;

    always #5 clk_sys = ~clk_sys;

    mlx_exec dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memWrEn(memWrEn), .memAddr(memAddr), .memData(memData),
        .swResetReq(swResetReq));

    // store port monitor: the pulse lasts one cycle, so it is caught at every edge
    always @(posedge clk_sys) begin
        if (memWrEn === 1'b1) begin
            storeCount <= storeCount + 1;
            lastAddr <= memAddr;
            lastData <= memData;
        end
        if (swResetReq === 1'b1) resetCount <= resetCount + 1;
    end

    task stop_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready, read data and error are all taken at the rising edge
    // that ends the access phase, and only then is the request released
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            errors++;
            stop_test();
        end
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // write an opcode, then poll busy with a bound
    task exec(input logic [13:0] op);
        int n;
        apb(1'b1, OFS_INSTR, {18'h0, op});
        for (n = 0; n < 20; n++) begin
            apb(1'b0, OFS_CORE, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        if (n == 20) begin
            errors++;
            stop_test();
        end
    endtask

    // pre forms address the moved pointer, post forms the old one
    function logic [15:0] eff_addr(input logic [15:0] p, input logic [1:0] m);
        eff_addr = (m == 2'b00) ? p + 16'h1 : (m == 2'b01) ? p - 16'h1 : p;
    endfunction

    function logic [15:0] new_ptr(input logic [15:0] p, input logic [1:0] m);
        new_ptr = m[0] ? p - 16'h1 : p + 16'h1;
    endfunction

    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(OFS_ACC, 32'h0);
        rdchk(OFS_OPTION, 32'hff);
        rdchk(OFS_POWER_CONTROL_REG, 32'h1);
        // unmapped place: error flagged, read gives zero
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        sts = $random(seed);
        apb(1'b1, OFS_STATUS, {24'h0, sts});
        for (int i = 0; i < 8; i++) begin
            bnk = (i == 0) ? 8'h1f : $random(seed);
            exec(14'h0020 | {9'h0, bnk[4:0]});
            rdchk(OFS_BANK, {27'h0, bnk[4:0]});
            f = (i == 0) ? 7'h7f : $random(seed);
            exec(14'h3180 | {7'h0, f});
            rdchk(OFS_PCH, {25'h0, f});
            acc = (i == 1) ? 8'hff : $random(seed);
            exec(14'h3000 | {6'h0, acc});
            rdchk(OFS_ACC, {24'h0, acc});
            f = (i == 0) ? 7'h7f : $random(seed);
            if (f < 7'h2) f = 7'h2;
            prev = storeCount;
            exec(14'h0080 | {7'h0, f});
            chk(storeCount, prev + 1);
            chk({16'h0, lastAddr}, {20'h0, bnk[4:0], f});
            chk({24'h0, lastData}, {24'h0, acc});
        end
        // every mode on both pointers, the first two across the wrap points
        for (int m = 0; m < 8; m++) begin
            p0 = (m == 0) ? 16'hffff : (m == 1) ? 16'h0000 : $random(seed);
            p1 = (m == 4) ? 16'hffff : (m == 5) ? 16'h0000 : $random(seed);
            apb(1'b1, OFS_PTR0, {16'h0, p0});
            apb(1'b1, OFS_PTR1, {16'h0, p1});
            pv = m[2] ? p1 : p0;
            exec(14'h0018 | m[2:0]);
            chk({16'h0, lastAddr}, {16'h0, eff_addr(pv, m[1:0])});
            chk({24'h0, lastData}, {24'h0, acc});
            rdchk(m[2] ? OFS_PTR1 : OFS_PTR0, {16'h0, new_ptr(pv, m[1:0])});
            rdchk(m[2] ? OFS_PTR0 : OFS_PTR1, {16'h0, m[2] ? p0 : p1});
            // keep the model of both pointers in step with the design
            if (m[2]) begin
                p1 = new_ptr(p1, m[1:0]);
            end else begin
                p0 = new_ptr(p0, m[1:0]);
            end
        end
        // signed offset form: both extremes, then random
        for (int i = 0; i < 6; i++) begin
            k = (i == 0) ? 6'h20 : (i == 1) ? 6'h1f : $random(seed);
            pv = i[0] ? p1 : p0;
            exec(14'h3f80 | {7'h0, i[0], k});
            chk({16'h0, lastAddr}, {16'h0, pv + {{10{k[5]}}, k}});
            rdchk(i[0] ? OFS_PTR1 : OFS_PTR0, {16'h0, pv});
        end
        // window places redirect to the pointer's address
        exec(14'h0080);
        chk({16'h0, lastAddr}, {16'h0, p0});
        exec(14'h0081);
        chk({16'h0, lastAddr}, {16'h0, p1});
        exec(OPC_OPTION);
        rdchk(OFS_OPTION, {24'h0, acc});
        apb(1'b0, OFS_PC, 32'h0);
        pv = rd[15:0];
        prev = storeCount;
        exec(OPC_NOP);
        rdchk(OFS_PC, {17'h0, pv[14:0] + 15'h1});
        rdchk(OFS_ACC, {24'h0, acc});
        chk(storeCount, prev);
        rdchk(OFS_STATUS, {24'h0, sts});
        prev = resetCount;
        exec(OPC_RESET);
        chk(resetCount, prev + 1);
        rdchk(OFS_POWER_CONTROL_REG, 32'h0);
        rdchk(OFS_ACC, 32'h0);
        rdchk(OFS_OPTION, 32'hff);
        apb(1'b1, OFS_POWER_CONTROL_REG, 32'h1);
        rdchk(OFS_POWER_CONTROL_REG, 32'h1);
        stop_test();
    end
endmodule
